/* File: rtl/opgen_pkg.sv */
package opgen_pkg;
   // ****************************************
   // Address map
   // ****************************************
   localparam logic [15:0] ROM_BASE = 16'h0000;
   localparam logic [15:0] ROM_LAST = 16'h7fff;
   localparam logic [15:0] IO_BASE = 16'hff00;
   localparam logic [15:0] IO_LAST = 16'hff7f;
   localparam logic [15:0] RAM_BASE = 16'hfb80;
   localparam logic [15:0] RAM_LAST = 16'hfeff;
   localparam logic [15:0] RAM2_BASE = 16'hff80;
   localparam logic [15:0] RAM2_LAST = 16'hffff;
   localparam logic [7:0] INDIRECT_PAGE = 8'h00;
   localparam logic [7:0] UNDEF_BYTE = 8'hff;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // ****************************************
   // Operand modes
   // ****************************************
   typedef enum logic [2:0] {
      MODE_NONE = 3'b000,
      MODE_SHORT_IMMEDIATE = 3'b001,
      MODE_LONG_IMMEDIATE = 3'b010,
      MODE_IMPLICIT = 3'b011,
      MODE_BIT_NUMBER = 3'b100,
      MODE_PC_RELATIVE = 3'b101,
      MODE_MEMORY_INDIRECT = 3'b110
   } operand_mode_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PTR_READ = 2'b01,
      ST_DONE = 2'b10
   } gen_state_type;
endpackage : opgen_pkg

/* File: rtl/area_decode.sv */
module area_decode
   import opgen_pkg::*;
(
   input wire logic [15:0] addr,
   output logic is_rom,
   output logic is_ram,
   output logic is_io,
   output logic is_empty
);
   // ****************************************
   // Area decode over the single 64 kbyte map
   // ****************************************
   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   assign is_rom = in_range(addr, ROM_BASE, ROM_LAST);
   assign is_io = in_range(addr, IO_BASE, IO_LAST);
   assign is_ram = in_range(addr, RAM_BASE, RAM_LAST) || in_range(addr, RAM2_BASE, RAM2_LAST);
   assign is_empty = !(is_rom || is_ram || is_io);
endmodule : area_decode

/* File: rtl/operand_addr_gen.sv */
// Functional notes
// - 8-bit immediate from byte two, 16-bit immediate from bytes three and four.
// - Long immediate accepted only for word_move; others limited to eight bits.
// - address_add_small and address_subtract_small take implicit value 1 or 2.
// - Bit instructions take 3-bit bit number from byte two or four.
// - Branch displacement in byte two sign-extended and added to pc.
// - Relative targets span -128 to +127 bytes from pc; displacement expected even.
// - Indirect jumps read word at 8-bit address in byte two as target.
// - Indirect pointer upper byte forced to zero, range 0000 to 00ff.
// - Odd branch target or word_move operand address has LSB cleared.
// - Peripheral registers use 8-bit path; ROM and RAM are full width.
// - Word write to peripherals writes only upper byte, lower dropped.
// - Word read from peripherals gives byte in upper half, lower undefined.
// - Writes to empty areas store nothing; reads return undefined data.
// - One 64-kbyte space holds program and data.
module operand_addr_gen
   import opgen_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   // Instruction side
   input wire logic op_start,
   input wire operand_mode_type op_mode,
   input wire logic [7:0] op_byte2,
   input wire logic [7:0] op_byte3,
   input wire logic [7:0] op_byte4,
   input wire logic op_word_move,
   input wire logic op_sel_two,
   input wire logic op_bit_in_byte4,
   input wire logic [15:0] pc,
   output logic op_busy,
   output logic op_done,
   output logic op_illegal,
   output logic [15:0] imm_value,
   output logic [2:0] bit_number,
   output logic [15:0] branch_target,
   // Data access from the core
   input wire logic acc_req,
   input wire logic acc_write,
   input wire logic acc_word,
   input wire logic [15:0] acc_addr,
   input wire logic [15:0] acc_wdata,
   output logic acc_ack,
   output logic [15:0] acc_rdata,
   // Memory and peripheral bus
   output logic mem_req,
   output logic mem_write,
   output logic [15:0] mem_addr,
   output logic mem_word,
   output logic [15:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata
);
   // ****************************************
   // Operand decode
   // ****************************************
   gen_state_type state_reg, state_next;
   logic [15:0] ptr_addr;
   logic [15:0] rel_target;
   logic [15:0] imm_sel;
   logic illegal_sel;
   logic [2:0] bit_sel;
   logic [15:0] imm_reg;
   logic [15:0] target_reg;
   logic [2:0] bit_reg;
   logic done_reg;
   logic illegal_reg;
   logic [15:0] acc_rdata_reg;
   logic acc_ack_reg;
   logic core_is_io;
   logic core_is_empty;
   logic core_is_rom;
   logic core_is_ram;
   logic [15:0] core_addr_even;
   logic io_word_write;

   function automatic logic [15:0] even_addr(input logic [15:0] a);
      even_addr = {a[15:1], 1'b0};
   endfunction : even_addr

   // Odd displacement tolerated; its LSB is cleared with the target
   function automatic logic [15:0] sext8(input logic [7:0] d);
      sext8 = {{8{d[7]}}, d};
   endfunction : sext8

   // Sign extension gives -128..+127 from pc; pc already points past the instruction
   assign rel_target = even_addr(pc + sext8(op_byte2));
   assign ptr_addr = {INDIRECT_PAGE, op_byte2};
   assign bit_sel = op_bit_in_byte4 ? op_byte4[2:0] : op_byte2[2:0];
   assign illegal_sel = (op_mode == MODE_LONG_IMMEDIATE) && !op_word_move;

   always_comb begin
      imm_sel = RESET_WORD;
      case (op_mode)
         MODE_SHORT_IMMEDIATE: imm_sel = {8'h00, op_byte2};
         MODE_LONG_IMMEDIATE: imm_sel = op_word_move ? {op_byte3, op_byte4} : RESET_WORD;
         MODE_IMPLICIT: imm_sel = op_sel_two ? 16'h0002 : 16'h0001;
         MODE_BIT_NUMBER: imm_sel = {13'h0000, bit_sel};
         default: imm_sel = RESET_WORD;
      endcase
   end

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (op_start && op_mode == MODE_MEMORY_INDIRECT) begin
               state_next = ST_PTR_READ;
            end else if (op_start) begin
               state_next = ST_DONE;
            end
         end
         ST_PTR_READ: begin
            if (mem_ack) begin
               state_next = ST_DONE;
            end
         end
         ST_DONE: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Results latched at start; indirect target latched when pointer word returns
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         imm_reg <= RESET_WORD;
         bit_reg <= 3'h0;
         target_reg <= RESET_WORD;
         illegal_reg <= 1'b0;
      end else if (state_reg == ST_IDLE && op_start) begin
         imm_reg <= imm_sel;
         bit_reg <= bit_sel;
         target_reg <= (op_mode == MODE_PC_RELATIVE) ? rel_target : target_reg;
         illegal_reg <= illegal_sel;
      end else if (state_reg == ST_PTR_READ && mem_ack) begin
         target_reg <= even_addr(mem_rdata);
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= (state_next == ST_DONE);
      end
   end

   // ****************************************
   // Operand outputs
   // ****************************************

   assign op_busy = (state_reg != ST_IDLE);
   assign op_done = done_reg;
   assign op_illegal = illegal_reg;
   assign imm_value = imm_reg;
   assign bit_number = bit_reg;
   assign branch_target = target_reg;

   // ****************************************
   // Data access path
   // ****************************************
   assign core_addr_even = acc_word ? even_addr(acc_addr) : acc_addr;

   area_decode u_area (
      .addr(core_addr_even),
      .is_rom(core_is_rom),
      .is_ram(core_is_ram),
      .is_io(core_is_io),
      .is_empty(core_is_empty)
   );

   // Pointer fetch owns the bus; core access waits while it runs
   logic ptr_phase;
   logic core_go;
   assign ptr_phase = (state_reg == ST_PTR_READ);
   assign core_go = acc_req && !ptr_phase && !core_is_empty;
   assign io_word_write = acc_word && core_is_io;

   assign mem_req = ptr_phase || core_go;
   assign mem_write = !ptr_phase && acc_write;
   assign mem_addr = ptr_phase ? ptr_addr : core_addr_even;
   // Peripheral access is always narrowed to a byte
   assign mem_word = ptr_phase || (acc_word && !core_is_io);
   // Word write to peripheral: upper byte goes out, lower byte lost
   assign mem_wdata = io_word_write ? {8'h00, acc_wdata[15:8]} : acc_wdata;

   // ****************************************
   // Core acknowledge and read data
   // ****************************************
   // Empty area answered locally; write dropped, read undefined
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         acc_ack_reg <= 1'b0;
         acc_rdata_reg <= RESET_WORD;
      end else begin
         acc_ack_reg <= acc_req && !ptr_phase && !acc_ack_reg && (core_is_empty || mem_ack);
         if (acc_req && !ptr_phase && core_is_empty && !acc_write) begin
            acc_rdata_reg <= {UNDEF_BYTE, UNDEF_BYTE};
         end else if (acc_req && !ptr_phase && mem_ack && !acc_write) begin
            if (io_word_write || (acc_word && core_is_io)) begin
               acc_rdata_reg <= {mem_rdata[7:0], UNDEF_BYTE};
            end else begin
               acc_rdata_reg <= mem_rdata;
            end
         end
      end
   end

   assign acc_ack = acc_ack_reg;
   assign acc_rdata = acc_rdata_reg;
endmodule : operand_addr_gen

/* File: verif/opgen_props.sv */
module opgen_props
   import opgen_pkg::*;
(
   input wire logic clk_sys, reset, op_start, op_busy, op_done, op_illegal,
   input wire operand_mode_type op_mode,
   input wire logic [7:0] op_byte2, op_byte3, op_byte4,
   input wire logic op_word_move, op_sel_two, op_bit_in_byte4, acc_req, acc_write,
   input wire logic acc_word, mem_req, mem_word,
   input wire logic [15:0] pc, imm_value, branch_target, acc_addr,
   input wire logic [15:0] acc_wdata, mem_addr, mem_wdata,
   input wire logic [2:0] bit_number
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Operand and access checks
   // ****************************************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   wire take = op_start && !op_busy;
   wire io = acc_addr >= IO_BASE && acc_addr <= IO_LAST;
   sequence s_take(operand_mode_type m);
      take && op_mode == m;
   endsequence
   sequence s_fetch;
      mem_req && mem_word && mem_addr[15:8] == INDIRECT_PAGE;
   endsequence
   property p_long;
      s_take(MODE_LONG_IMMEDIATE) |=> op_done && op_illegal != $past(op_word_move) &&
         imm_value == ($past(op_word_move) ? {$past(op_byte3), $past(op_byte4)} : 16'h0000);
   endproperty
   a_long: assert property (p_long) else $error("long imm");
   property p_short;
      s_take(MODE_SHORT_IMMEDIATE) |=> op_done && imm_value == {8'h00, $past(op_byte2)};
   endproperty
   a_short: assert property (p_short) else $error("short imm");
   property p_impl;
      s_take(MODE_IMPLICIT) |=> imm_value == ($past(op_sel_two) ? 16'h0002 : 16'h0001);
   endproperty
   a_impl: assert property (p_impl) else $error("implicit imm");
   property p_bit;
      s_take(MODE_BIT_NUMBER) |=>
         bit_number == ($past(op_bit_in_byte4) ? $past(op_byte4[2:0]) : $past(op_byte2[2:0]));
   endproperty
   a_bit: assert property (p_bit) else $error("bit number");
   property p_rel;
      s_take(MODE_PC_RELATIVE) |=> op_done && branch_target ==
         (($past(pc) + {{8{$past(op_byte2[7])}}, $past(op_byte2)}) & 16'hfffe);
   endproperty
   a_rel: assert property (p_rel) else $error("relative target");
   property p_ptr;
      s_take(MODE_MEMORY_INDIRECT) |=> s_fetch ##0 mem_addr[7:1] == $past(op_byte2[7:1]);
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer fetch");
   property p_iow;
      acc_req && acc_write && acc_word && io && mem_req && !op_busy |->
         !mem_word && mem_wdata[7:0] == acc_wdata[15:8];
   endproperty
   a_iow: assert property (p_iow) else $error("io word write");
   property p_empty;
      acc_req && acc_write && !op_busy && acc_addr > ROM_LAST && acc_addr < RAM_BASE |->
         !mem_req;
   endproperty
   a_empty: assert property (p_empty) else $error("empty write");
   property p_even;
      acc_req && acc_word && !io && !op_busy && mem_req |-> mem_addr == {acc_addr[15:1], 1'b0};
   endproperty
   a_even: assert property (p_even) else $error("odd word address");
endmodule : opgen_props
bind operand_addr_gen opgen_props opgen_props_i (.*);

/* File: verif/mem_model.sv */
module mem_model
(
   input wire logic clk_sys, slow, mem_req, mem_write, mem_word,
   input wire logic [15:0] mem_addr, mem_wdata,
   output logic mem_ack,
   output logic [15:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Byte memory, prompt or slow
   // ****************************************
   logic [7:0] mem [256];
   logic [1:0] wait_reg = 2'h0;
   logic [15:0] last_reg = 16'h0000;
   wire [7:0] ev = {mem_addr[7:1], 1'b0};
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
   assign mem_ack = mem_req && (!slow || wait_reg == 2'h2);
   // Idle bus shows inverted data so stale values never pass
   assign mem_rdata = !mem_ack ? ~last_reg : mem_word ? {mem[ev], mem[ev + 8'h01]}
      : {8'h00, mem[mem_addr[7:0]]};
   always @(posedge clk_sys) begin
      wait_reg <= mem_req && !mem_ack ? wait_reg + 2'h1 : 2'h0;
      if (mem_ack) last_reg <= mem_rdata;
      if (mem_ack && mem_write && mem_word) {mem[ev], mem[ev + 8'h01]} <= mem_wdata;
      else if (mem_ack && mem_write) mem[mem_addr[7:0]] <= mem_wdata[7:0];
   end
endmodule : mem_model

/* File: verif/tb_operand_addr_gen.sv */
module tb_operand_addr_gen import opgen_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Stimulus, queue and monitor
   // ****************************************
   logic clk_sys = 1'b0, reset = 1'b1, op_start = 1'b0, op_word_move = 1'b0, op_sel_two = 1'b0;
   logic op_bit_in_byte4 = 1'b0, acc_req = 1'b0, acc_write = 1'b0, acc_word = 1'b0, slow = 1'b0;
   operand_mode_type op_mode = MODE_NONE;
   logic [7:0] op_byte2 = 8'h00, op_byte3 = 8'h00, op_byte4 = 8'h00, r;
   logic [15:0] pc = 16'h0000, acc_addr = 16'h0000, acc_wdata = 16'h0000, p;
   logic op_busy, op_done, op_illegal, acc_ack, mem_req, mem_write, mem_word, mem_ack;
   logic [2:0] bit_number;
   logic [15:0] imm_value, branch_target, acc_rdata, mem_addr, mem_wdata, mem_rdata;
   logic [7:0] d [4] = '{8'h80, 8'h7e, 8'h82, 8'h81};
   logic [17:0] exp_q [$];
   int err_total = 0, n_compared = 0, cycles = 0;
   operand_addr_gen operand_addr_gen_i (.*);
   mem_model mem_model_i (.*);
   initial forever #10 clk_sys = ~clk_sys;
   task automatic op(operand_mode_type m, logic [7:0] b2, b3, b4, logic [2:0] f,
         logic [15:0] pv, logic [1:0] k, logic [15:0] v);
      exp_q.push_back({k, v});
      @(posedge clk_sys);
      op_mode <= m;
      {op_byte2, op_byte3, op_byte4, pc} <= {b2, b3, b4, pv};
      {op_word_move, op_sel_two, op_bit_in_byte4, op_start} <= {f, 1'b1};
      @(posedge clk_sys);
      op_start <= 1'b0;
      #1;
      while (!op_done) @(posedge clk_sys) #1;
   endtask : op
   task automatic acc(logic w, wd, logic [15:0] a, dt, v, logic e);
      if (!w) exp_q.push_back({2'd3, v});
      @(posedge clk_sys);
      {acc_req, acc_write, acc_word, acc_addr, acc_wdata} <= {1'b1, w, wd, a, dt};
      do @(negedge clk_sys); while (!mem_ack && !e);
      @(posedge clk_sys);
      acc_req <= 1'b0;
      @(posedge clk_sys);
   endtask : acc
   task report_and_stop;
      if (err_total == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   always @(posedge clk_sys) begin
      logic [17:0] e;
      logic [15:0] g;
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         report_and_stop();
      end
      #1;
      if ((op_done || (acc_ack && !acc_write)) && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         g = e[17:16] == 2'd0 ? imm_value : e[17:16] == 2'd1 ? {13'h0000, bit_number}
            : e[17:16] == 2'd2 ? branch_target : acc_rdata;
         n_compared++;
         if (g !== e[15:0]) begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, g, e[15:0]);
         end
      end
   end
   initial begin
      void'($urandom(32'h277d7a5a));
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (3) begin
         r = 8'($urandom());
         op(MODE_SHORT_IMMEDIATE, r, 8'h00, 8'h00, 3'b000, pc, 2'd0, {8'h00, r});
         op(MODE_BIT_NUMBER, r, 8'h00, 8'h00, 3'b000, pc, 2'd1, {13'h0000, r[2:0]});
      end
      op(MODE_BIT_NUMBER, 8'h00, 8'h00, 8'h0d, 3'b001, pc, 2'd1, 16'h0005);
      op(MODE_LONG_IMMEDIATE, r, 8'h12, 8'h34, 3'b100, pc, 2'd0, 16'h1234);
      op(MODE_LONG_IMMEDIATE, r, 8'h12, 8'h34, 3'b000, pc, 2'd0, 16'h0000);
      op(MODE_IMPLICIT, r, 8'h00, 8'h00, 3'b000, pc, 2'd0, 16'h0001);
      op(MODE_IMPLICIT, r, 8'h00, 8'h00, 3'b010, pc, 2'd0, 16'h0002);
      foreach (d[i]) begin
         p = 16'($urandom());
         op(MODE_PC_RELATIVE, d[i], 8'h00, 8'h00, 3'b000, p, 2'd2,
            (p + {{8{d[i][7]}}, d[i]}) & 16'hfffe);
      end
      op(MODE_MEMORY_INDIRECT, 8'h41, 8'h00, 8'h00, 3'b000, pc, 2'd2, 16'h1a1a);
      slow <= 1'b1;
      op(MODE_MEMORY_INDIRECT, 8'hc6, 8'h00, 8'h00, 3'b000, pc, 2'd2, 16'h9c9c);
      acc(1'b1, 1'b1, 16'hfb90, 16'h1234, 16'h0000, 1'b0);
      acc(1'b0, 1'b1, 16'hfb91, 16'h0000, 16'h1234, 1'b0);
      slow <= 1'b0;
      acc(1'b1, 1'b1, 16'hff20, 16'habcd, 16'h0000, 1'b0);
      acc(1'b0, 1'b1, 16'hff20, 16'h0000, {8'hab, UNDEF_BYTE}, 1'b0);
      acc(1'b1, 1'b1, 16'h9000, 16'h5555, 16'h0000, 1'b1);
      acc(1'b0, 1'b1, 16'h9000, 16'h0000, 16'hffff, 1'b1);
      acc(1'b0, 1'b1, 16'h0050, 16'h0000, 16'h0a0b, 1'b0);
      repeat (4) @(posedge clk_sys);
      report_and_stop();
   end
endmodule : tb_operand_addr_gen
